/* hw/chan_sel_pkg.sv */
package chan_sel_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BUS_SETUP_NS = 250;
    localparam int unsigned TAG_SETUP_NS = 100;
    localparam int unsigned SEL_DELAY_NS = 400;
    localparam int unsigned IGNORE_NS = 1500;
    localparam int unsigned HOLD_LONG_NS = 4000;
    localparam int unsigned HOLD_SHORT_NS = 2000;

    localparam int unsigned BUS_SETUP_CYC = (BUS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TAG_SETUP_CYC = (TAG_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SEL_DELAY_CYC = (SEL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IGNORE_CYC = (IGNORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_LONG_CYC = (HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_SHORT_CYC = (HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned TIMER_W = 10;
    typedef logic [TIMER_W-1:0] count_t;
    localparam count_t TIMER_RESET = 10'h000;
    localparam count_t HOLD_CNT_RESET = 10'h3ff;
    localparam logic [7:0] BUS_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef struct packed {
        logic operational;
        logic address;
        logic select;
        logic hold;
        logic command;
        logic service;
    } out_tags_s;

    typedef struct packed {
        logic operational;
        logic select_ret;
        logic address;
        logic status;
        logic service;
        logic request;
    } in_tags_s;

    localparam out_tags_s OUT_TAGS_RESET = 6'h00;
    localparam in_tags_s IN_TAGS_RESET = 6'h00;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR_SETUP = 4'h1,
        ST_SEL_WAIT = 4'h3,
        ST_SELECTING = 4'h2,
        ST_CMD = 4'h6,
        ST_STATUS_WAIT = 4'h7,
        ST_TAG_ACK = 4'h5,
        ST_HOLD_OFF = 4'h4,
        ST_RET_WAIT = 4'hc,
        ST_BUSY_WAIT = 4'hd
    } state_e;

    typedef enum logic [1:0] {
        RES_OK = 2'h0,
        RES_NO_UNIT = 2'h1,
        RES_SHORT_BUSY = 2'h2,
        RES_POLLED = 2'h3
    } result_e;

endpackage

/* hw/chan_sel_host.sv */
`timescale 1ns/1ps
module chan_sel_host (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] start_addr,
    input wire logic [7:0] start_cmd,
    input wire logic poll_enable,
    input wire logic stack_status,
    input wire logic hold_short,
    input wire chan_sel_pkg::in_tags_s tags_in,
    input wire logic [7:0] bus_in,
    output chan_sel_pkg::out_tags_s tags_out,
    output logic [7:0] bus_out,
    output logic bus_out_parity,
    output logic busy,
    output logic done,
    output chan_sel_pkg::result_e result,
    output logic [7:0] addr_back,
    output logic [7:0] status_back
);

    chan_sel_pkg::in_tags_s tags_meta;
    chan_sel_pkg::in_tags_s tags_q;
    chan_sel_pkg::state_e state;
    chan_sel_pkg::count_t timer;
    chan_sel_pkg::count_t hold_low_cnt;
    chan_sel_pkg::count_t hold_min;
    logic polling;
    logic inbound_quiet;
    logic hold_ok;

    // Two-stage capture of every inbound tag line before any decision; bus_in is not captured
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tags_meta <= chan_sel_pkg::IN_TAGS_RESET;
            tags_q <= chan_sel_pkg::IN_TAGS_RESET;
        end
        else
        begin
            tags_meta <= tags_in;
            tags_q <= tags_meta;
        end
    end

    // Hold low time counted from its fall; saturates so an idle link is ready
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            hold_low_cnt <= chan_sel_pkg::HOLD_CNT_RESET;
        else if (tags_out.hold)
            hold_low_cnt <= chan_sel_pkg::TIMER_RESET;
        else if (hold_low_cnt != chan_sel_pkg::HOLD_CNT_RESET)
            hold_low_cnt <= hold_low_cnt + 10'h001;
    end

    assign hold_min = hold_short ? chan_sel_pkg::count_t'(chan_sel_pkg::HOLD_SHORT_CYC)
                                 : chan_sel_pkg::count_t'(chan_sel_pkg::HOLD_LONG_CYC);
    assign hold_ok = hold_low_cnt >= hold_min;
    // Request is the only inbound line allowed up between sequences
    assign inbound_quiet = !tags_q.operational && !tags_q.select_ret && !tags_q.address
                           && !tags_q.status && !tags_q.service;
    assign busy = state != chan_sel_pkg::ST_IDLE;
    assign bus_out_parity = ~^bus_out;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state <= chan_sel_pkg::ST_IDLE;
            timer <= chan_sel_pkg::TIMER_RESET;
            tags_out <= chan_sel_pkg::OUT_TAGS_RESET;
            bus_out <= chan_sel_pkg::BUS_RESET;
            polling <= 1'b0;
            done <= 1'b0;
            result <= chan_sel_pkg::RES_OK;
            addr_back <= chan_sel_pkg::BUS_RESET;
            status_back <= chan_sel_pkg::BUS_RESET;
        end
        else
        begin
            done <= 1'b0;
            tags_out.operational <= 1'b1;
            if (timer != chan_sel_pkg::TIMER_RESET)
                timer <= timer - 10'h001;
            case (state)
                chan_sel_pkg::ST_IDLE:
                begin
                    if (inbound_quiet && hold_ok && tags_out.operational)
                    begin
                        if (start)
                        begin
                            bus_out <= start_addr;
                            polling <= 1'b0;
                            timer <= chan_sel_pkg::count_t'(chan_sel_pkg::BUS_SETUP_CYC);
                            state <= chan_sel_pkg::ST_ADDR_SETUP;
                        end
                        else if (poll_enable && tags_q.request)
                        begin
                            // Unit-initiated: select goes out with no address
                            polling <= 1'b1;
                            tags_out.select <= 1'b1;
                            tags_out.hold <= 1'b1;
                            state <= chan_sel_pkg::ST_SELECTING;
                        end
                    end
                end
                chan_sel_pkg::ST_ADDR_SETUP:
                begin
                    if (timer == chan_sel_pkg::TIMER_RESET)
                    begin
                        tags_out.address <= 1'b1;
                        timer <= chan_sel_pkg::count_t'(chan_sel_pkg::SEL_DELAY_CYC);
                        state <= chan_sel_pkg::ST_SEL_WAIT;
                    end
                end
                chan_sel_pkg::ST_SEL_WAIT:
                begin
                    if (timer == chan_sel_pkg::TIMER_RESET)
                    begin
                        tags_out.select <= 1'b1;
                        tags_out.hold <= 1'b1;
                        state <= chan_sel_pkg::ST_SELECTING;
                    end
                end
                chan_sel_pkg::ST_SELECTING:
                begin
                    // Return of select means every unit in chain order passed
                    if (tags_q.select_ret)
                    begin
                        tags_out.select <= 1'b0;
                        tags_out.hold <= 1'b0;
                        state <= chan_sel_pkg::ST_RET_WAIT;
                    end
                    else if (tags_q.status && !polling)
                    begin
                        status_back <= bus_in;
                        tags_out.select <= 1'b0;
                        tags_out.hold <= 1'b0;
                        state <= chan_sel_pkg::ST_BUSY_WAIT;
                    end
                    else if (tags_q.operational)
                    begin
                        tags_out.address <= 1'b0;
                        if (tags_q.address)
                        begin
                            addr_back <= bus_in;
                            bus_out <= polling ? chan_sel_pkg::ZERO_BYTE : start_cmd;
                            tags_out.select <= 1'b0;
                            tags_out.hold <= 1'b0;
                            timer <= chan_sel_pkg::count_t'(chan_sel_pkg::TAG_SETUP_CYC);
                            state <= chan_sel_pkg::ST_CMD;
                        end
                    end
                end
                chan_sel_pkg::ST_RET_WAIT:
                begin
                    if (!tags_q.select_ret)
                    begin
                        tags_out.address <= 1'b0;
                        result <= chan_sel_pkg::RES_NO_UNIT;
                        timer <= chan_sel_pkg::count_t'(chan_sel_pkg::IGNORE_CYC);
                        state <= chan_sel_pkg::ST_HOLD_OFF;
                    end
                end
                chan_sel_pkg::ST_BUSY_WAIT:
                begin
                    if (!tags_q.status)
                    begin
                        tags_out.address <= 1'b0;
                        result <= chan_sel_pkg::RES_SHORT_BUSY;
                        timer <= chan_sel_pkg::count_t'(chan_sel_pkg::IGNORE_CYC);
                        state <= chan_sel_pkg::ST_HOLD_OFF;
                    end
                end
                chan_sel_pkg::ST_CMD:
                begin
                    if (!tags_out.command && timer == chan_sel_pkg::TIMER_RESET)
                        tags_out.command <= 1'b1;
                    else if (tags_out.command && !tags_q.address)
                    begin
                        tags_out.command <= 1'b0;
                        state <= chan_sel_pkg::ST_STATUS_WAIT;
                    end
                end
                chan_sel_pkg::ST_STATUS_WAIT:
                begin
                    if (!tags_q.operational)
                    begin
                        result <= polling ? chan_sel_pkg::RES_POLLED : chan_sel_pkg::RES_OK;
                        timer <= chan_sel_pkg::count_t'(chan_sel_pkg::IGNORE_CYC);
                        state <= chan_sel_pkg::ST_HOLD_OFF;
                    end
                    else if (tags_q.status)
                    begin
                        status_back <= bus_in;
                        bus_out <= chan_sel_pkg::ZERO_BYTE;
                        tags_out.command <= stack_status;
                        tags_out.service <= !stack_status;
                        state <= chan_sel_pkg::ST_TAG_ACK;
                    end
                    else if (tags_q.service)
                    begin
                        // Data transfer is not handled here, so data requests get stop
                        bus_out <= chan_sel_pkg::ZERO_BYTE;
                        tags_out.command <= 1'b1;
                        state <= chan_sel_pkg::ST_TAG_ACK;
                    end
                end
                chan_sel_pkg::ST_TAG_ACK:
                begin
                    if (!tags_q.status && !tags_q.service)
                    begin
                        tags_out.command <= 1'b0;
                        tags_out.service <= 1'b0;
                        state <= chan_sel_pkg::ST_STATUS_WAIT;
                    end
                end
                chan_sel_pkg::ST_HOLD_OFF:
                begin
                    // Inbound tags are not looked at while this runs
                    if (timer == chan_sel_pkg::TIMER_RESET)
                    begin
                        done <= 1'b1;
                        state <= chan_sel_pkg::ST_IDLE;
                    end
                end
                default:
                    state <= chan_sel_pkg::ST_IDLE;
            endcase
        end
    end

    property p_cmd_alone;
        @(posedge clk_sys) disable iff (rst)
        tags_out.command |-> !tags_out.service && !tags_out.select && !tags_out.address;
    endproperty
    a_cmd_alone: assert property (p_cmd_alone) else $error("command up with another tag");

    property p_sel_delay;
        @(posedge clk_sys) disable iff (rst)
        $rose(tags_out.select) && tags_out.address |-> $past(tags_out.address, 40);
    endproperty
    a_sel_delay: assert property (p_sel_delay) else $error("select too soon after address");

    property p_ret_drop;
        @(posedge clk_sys) disable iff (rst)
        tags_out.select && tags_q.select_ret |=> !tags_out.select ##1 !tags_out.select;
    endproperty
    a_ret_drop: assert property (p_ret_drop) else $error("select kept after return");

    property p_ret_low;
        @(posedge clk_sys) disable iff (rst)
        $rose(tags_out.select) |-> !tags_q.select_ret;
    endproperty
    a_ret_low: assert property (p_ret_low) else $error("select raised while return high");

    property p_hold_low;
        @(posedge clk_sys) disable iff (rst)
        $rose(tags_out.hold) |-> $past(hold_low_cnt) >= $past(hold_min);
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("hold low time too short");

    property p_busy_sel;
        @(posedge clk_sys) disable iff (rst)
        state == chan_sel_pkg::ST_BUSY_WAIT |-> !tags_out.select && tags_out.address;
    endproperty
    a_busy_sel: assert property (p_busy_sel) else $error("select up during short busy");

    property p_cmd_interlock;
        @(posedge clk_sys) disable iff (rst)
        $fell(tags_out.command) |-> !$past(tags_q.address) && !$past(tags_q.status);
    endproperty
    a_cmd_interlock: assert property (p_cmd_interlock) else $error("command fell early");

    property p_cmd_stays;
        @(posedge clk_sys) disable iff (rst)
        tags_out.command && tags_q.address |=> tags_out.command;
    endproperty
    a_cmd_stays: assert property (p_cmd_stays) else $error("command dropped under tag");

    property p_zero_byte;
        @(posedge clk_sys) disable iff (rst)
        (tags_out.command && (polling || state == chan_sel_pkg::ST_TAG_ACK)) || tags_out.service
        |-> bus_out == chan_sel_pkg::ZERO_BYTE;
    endproperty
    a_zero_byte: assert property (p_zero_byte) else $error("nonzero byte on proceed");

    property p_sel_kept;
        @(posedge clk_sys) disable iff (rst)
        state == chan_sel_pkg::ST_SELECTING && !tags_q.select_ret && !tags_q.status
        && !(tags_q.operational && tags_q.address) |=> tags_out.select;
    endproperty
    a_sel_kept: assert property (p_sel_kept) else $error("select dropped early");

    property p_quiet_gap;
        @(posedge clk_sys) disable iff (rst)
        $fell(tags_q.operational) && busy |-> !done [*8];
    endproperty
    a_quiet_gap: assert property (p_quiet_gap) else $error("sequence ended without gap");

    c_no_unit: cover property (@(posedge clk_sys) result == chan_sel_pkg::RES_NO_UNIT && done);
    c_short_busy: cover property (@(posedge clk_sys) result == chan_sel_pkg::RES_SHORT_BUSY && done);
    c_claim_ok: cover property (@(posedge clk_sys) result == chan_sel_pkg::RES_OK && done);
    c_polled: cover property (@(posedge clk_sys) result == chan_sel_pkg::RES_POLLED && done);

endmodule

/* tb/unit_chain_model.sv */
`timescale 1ns/1ps
module unit_chain_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire chan_sel_pkg::out_tags_s tags_out,
    input wire logic [7:0] bus_out,
    input wire logic [1:0] mode,
    input wire logic [7:0] unit_addr,
    input wire logic [7:0] status_byte,
    input wire logic [7:0] lag,
    output chan_sel_pkg::in_tags_s tags_in,
    output logic [7:0] bus_in,
    output logic [7:0] cmd_seen,
    output logic [7:0] zero_seen,
    output logic stacked
);
    // Mode 0 claims on address match, 1 claims then asks for data,
    // 2 answers short-busy, 3 requests a poll
    logic sel_latch, sel_prev, out_quiet, match;
    logic [2:0] phase;
    logic [7:0] wait_cnt;

    assign out_quiet = !(tags_out.command | tags_out.select | tags_out.hold
        | tags_out.service | tags_out.address);
    assign match = tags_out.address && bus_out == unit_addr;

    // Glitches on select cannot reach downstream while hold is up
    always_ff @(posedge clk_sys)
    begin
        if (rst || !tags_out.hold)
            sel_latch <= 1'h0;
        else if (tags_out.select)
            sel_latch <= 1'h1;
        sel_prev <= sel_latch;
    end

    always_ff @(posedge clk_sys)
    begin
        // A released bus never keeps its last byte
        bus_in <= rst ? 8'h96 : ~bus_in;
        if (rst || !tags_out.operational)
        begin
            tags_in <= chan_sel_pkg::IN_TAGS_RESET;
            phase <= 3'h0;
            wait_cnt <= 8'h00;
        end
        else
        begin
            tags_in.request <= mode == 2'h3 && phase == 3'h0;
            wait_cnt <= (phase == 3'h0) ? 8'h00 : wait_cnt + 8'h01;
            if (phase != 3'h0 && phase != 3'h6)
                bus_in <= bus_in;
            case (phase)
            3'h0:
                if (sel_latch && !sel_prev)
                begin
                    // Claim only at a rising select, never forwarding it then
                    if ((!mode[1] && match) || (mode == 2'h3 && !tags_out.address))
                    begin
                        tags_in.operational <= 1'h1;
                        tags_in.address <= 1'h1;
                        bus_in <= unit_addr;
                        cmd_seen <= 8'hee;
                        zero_seen <= 8'hee;
                        phase <= 3'h1;
                    end
                    else if (mode == 2'h2 && match)
                    begin
                        tags_in.status <= 1'h1;
                        bus_in <= status_byte;
                        phase <= 3'h5;
                    end
                    else
                        phase <= 3'h6;
                end
            3'h1:
                if (tags_out.command)
                begin
                    tags_in.address <= 1'h0;
                    cmd_seen <= bus_out;
                    phase <= 3'h2;
                end
            3'h2:
                if (out_quiet && wait_cnt > lag)
                begin
                    // Mode 1 asks for a data byte, which the block answers with stop
                    tags_in.status <= mode != 2'h1;
                    tags_in.service <= mode == 2'h1;
                    bus_in <= status_byte;
                    phase <= 3'h3;
                end
            3'h3:
                if (tags_out.command || tags_out.service)
                begin
                    tags_in.status <= 1'h0;
                    tags_in.service <= 1'h0;
                    stacked <= tags_out.command;
                    zero_seen <= bus_out;
                    phase <= 3'h4;
                end
            3'h4:
                if (!tags_out.command && !tags_out.service && !tags_out.select)
                begin
                    tags_in <= chan_sel_pkg::IN_TAGS_RESET;
                    phase <= 3'h0;
                end
            3'h5:
                if (!tags_out.select)
                begin
                    tags_in.status <= 1'h0;
                    phase <= 3'h0;
                end
            3'h6:
            begin
                tags_in.select_ret <= sel_latch && wait_cnt > 8'h14;
                if (!sel_latch)
                    phase <= 3'h0;
            end
            default:
                phase <= 3'h0;
            endcase
        end
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk_sys, rst, start, poll_enable, stack_status, hold_short;
    logic busy, done, stacked, sel_prev, hold_prev, parity;
    logic [7:0] start_addr, start_cmd, bus_in, bus_out, addr_back, status_back;
    logic [7:0] unit_addr, status_byte, lag, cmd_seen, zero_seen;
    logic [1:0] mode;
    chan_sel_pkg::in_tags_s tags_in;
    chan_sel_pkg::out_tags_s tags_out;
    chan_sel_pkg::result_e result;
    int fail_count, n_checks, addr_age, hold_low;

    chan_sel_host i_dut (.clk_sys(clk_sys), .rst(rst), .start(start),
        .start_addr(start_addr), .start_cmd(start_cmd), .poll_enable(poll_enable),
        .stack_status(stack_status), .hold_short(hold_short), .tags_in(tags_in),
        .bus_in(bus_in), .tags_out(tags_out), .bus_out(bus_out), .bus_out_parity(parity),
        .busy(busy), .done(done), .result(result), .addr_back(addr_back),
        .status_back(status_back));

    unit_chain_model i_unit (.clk_sys(clk_sys), .rst(rst), .tags_out(tags_out),
        .bus_out(bus_out), .mode(mode), .unit_addr(unit_addr),
        .status_byte(status_byte), .lag(lag), .tags_in(tags_in), .bus_in(bus_in),
        .cmd_seen(cmd_seen), .zero_seen(zero_seen), .stacked(stacked));

    initial
    begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Timing rules on the outbound side are watched continuously
    always @(posedge clk_sys)
    begin
        sel_prev <= tags_out.select;
        hold_prev <= tags_out.hold;
        addr_age <= tags_out.address ? addr_age + 1 : 0;
        hold_low <= (rst || tags_out.hold) ? (rst ? 100000 : 0) : hold_low + 1;
        if (!rst && tags_out.command && (tags_out.address | tags_out.select
            | tags_out.hold | tags_out.service))
            chk(8'h01, 8'h00);
        if (!rst && tags_out.select && !sel_prev && tags_out.address)
            chk({7'h00, addr_age >= chan_sel_pkg::SEL_DELAY_CYC}, 8'h01);
        if (!rst && tags_out.select && !sel_prev)
            chk({7'h00, tags_in.select_ret}, 8'h00);
        if (!rst && tags_out.hold && !hold_prev)
            chk({7'h00, hold_low >= (hold_short ? chan_sel_pkg::HOLD_SHORT_CYC
                : chan_sel_pkg::HOLD_LONG_CYC)}, 8'h01);
        // Odd parity over the byte and its parity bit, zero bytes included
        if (!rst)
            chk({7'h00, ^{bus_out, parity}}, 8'h01);
    end

    task automatic wait_done(input int limit);
        int i;
        for (i = 0; i < limit && done !== 1'h1; i++)
            @(posedge clk_sys);
        chk({7'h00, done}, 8'h01);
    endtask

    // Start is held as a level: the hold minimum may still refuse it
    task automatic run_start(input logic [7:0] addr, input logic [7:0] cmd);
        int i;
        start <= 1'h1;
        start_addr <= addr;
        start_cmd <= cmd;
        @(posedge clk_sys);
        for (i = 0; i < 1000 && busy !== 1'h1; i++)
            @(posedge clk_sys);
        start <= 1'h0;
        wait_done(3000);
    endtask

    task automatic t_reset;
        chk({7'h00, tags_out.operational}, 8'h00);
        chk(bus_out, 8'h00);
        rst <= 1'h0;
        repeat (3) @(posedge clk_sys);
        chk({7'h00, tags_out.operational}, 8'h01);
    endtask

    task automatic t_claim(input logic stack, input logic fast);
        mode <= 2'h0;
        stack_status <= stack;
        hold_short <= fast;
        lag <= fast ? 8'h00 : 8'h30;
        run_start(8'h5a, 8'h03);
        chk({6'h00, result}, {6'h00, chan_sel_pkg::RES_OK});
        chk(addr_back, 8'h5a);
        chk(status_back, 8'h0c);
        chk(cmd_seen, 8'h03);
        chk({7'h00, stacked}, {7'h00, stack});
        chk(zero_seen, 8'h00);
    endtask

    // The unit asks for data instead of status; the block answers with stop
    task automatic t_stop;
        mode <= 2'h1;
        stack_status <= 1'h0;
        run_start(8'h5a, 8'h07);
        mode <= 2'h0;
        chk({6'h00, result}, {6'h00, chan_sel_pkg::RES_OK});
        chk(cmd_seen, 8'h07);
        chk({7'h00, stacked}, 8'h01);
        chk(zero_seen, 8'h00);
    endtask

    // Back to the long hold minimum, measured from a real fall of hold
    task automatic t_no_unit;
        hold_short <= 1'h0;
        run_start(8'h33, 8'h03);
        chk({6'h00, result}, {6'h00, chan_sel_pkg::RES_NO_UNIT});
    endtask

    task automatic t_short_busy;
        mode <= 2'h2;
        status_byte <= 8'h10;
        run_start(8'h5a, 8'h03);
        chk({6'h00, result}, {6'h00, chan_sel_pkg::RES_SHORT_BUSY});
        chk(status_back, 8'h10);
    endtask

    task automatic t_polled;
        int i;
        mode <= 2'h3;
        unit_addr <= 8'h21;
        status_byte <= 8'h0c;
        poll_enable <= 1'h1;
        @(posedge clk_sys);
        for (i = 0; i < 1000 && busy !== 1'h1; i++)
            @(posedge clk_sys);
        // The request stays up afterwards, so polling is closed at once
        poll_enable <= 1'h0;
        wait_done(3000);
        mode <= 2'h0;
        chk({6'h00, result}, {6'h00, chan_sel_pkg::RES_POLLED});
        chk(addr_back, 8'h21);
        chk(cmd_seen, 8'h00);
    endtask

    initial
    begin
        rst = 1'h1;
        start = 1'h0;
        start_addr = 8'h00;
        start_cmd = 8'h00;
        poll_enable = 1'h0;
        stack_status = 1'h0;
        hold_short = 1'h0;
        mode = 2'h0;
        unit_addr = 8'h5a;
        status_byte = 8'h0c;
        lag = 8'h00;
        fail_count = 0;
        n_checks = 0;
        repeat (5) @(posedge clk_sys);
        t_reset();
        t_claim(1'h0, 1'h0);
        t_claim(1'h1, 1'h1);
        t_stop();
        t_no_unit();
        t_short_busy();
        t_polled();
        end_sim();
    end

    initial
    begin
        repeat (50000) @(posedge clk_sys);
        fail_count++;
        end_sim();
    end
endmodule
